// ---- src/isarr_pkg.sv ----
// constants for the isa resource routing block
package isarr_pkg;
	// ************************************
	// host configuration ports
	// ************************************
	localparam logic [15:0] CFG_INDEX_ADDR = 16'h03f0;
	localparam logic [15:0] CFG_DATA_ADDR = 16'h03f1;
	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_ACT = 8'h30;
	localparam logic [7:0] IDX_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_IRQ = 8'h70;
	localparam logic [7:0] IDX_DMA = 8'h74;
	// ************************************
	// reset values
	// ************************************
	localparam logic [7:0] RST_ACT = 8'h00;
	localparam logic [7:0] RST_BASE = 8'h00;
	localparam logic [7:0] RST_IRQ = 8'h00;
	localparam logic [7:0] RST_DMA = 8'h04;
	localparam logic [7:0] RST_LDN = 8'h00;
	// ************************************
	// logical units
	// ************************************
	localparam int UNIT_N = 5;
	localparam int U_FDC = 0;
	localparam int U_PP = 1;
	localparam int U_SP1 = 2;
	localparam int U_SP2 = 3;
	localparam int U_KBD = 4;
	localparam logic [2:0] LDN_FDC = 3'h0;
	localparam logic [2:0] LDN_PP = 3'h3;
	localparam logic [2:0] LDN_SP1 = 3'h4;
	localparam logic [2:0] LDN_SP2 = 3'h5;
	localparam logic [2:0] LDN_KBD = 3'h7;
	// ************************************
	// address decode limits
	// ************************************
	localparam logic [11:0] BASE_MIN = 12'h100;
	localparam logic [11:0] BASE_MAX8 = 12'hff8;
	localparam logic [11:0] BASE_MAX4 = 12'hffc;
	localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
	localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
	localparam logic [11:0] ECP_OFS = 12'h400;
	// ************************************
	// unit control bit positions
	// ************************************
	localparam int DOR_DMA_BIT = 3;
	localparam int PP_PPORT_INT_GATE_BIT = 4;
	localparam int ECR_SVC_BIT = 2;
	localparam int ECR_DMA_BIT = 3;
	localparam int ECR_MODE_LSB = 5;
	localparam logic [2:0] ECR_MODE_ECP = 3'h3;
	localparam logic [2:0] ECR_MODE_EPP = 3'h4;
	localparam int MCR_UART_IRQ_OUTPUT_GATE_BIT = 2;
	localparam logic [15:0] PAR_IRQ_MASK = 16'h1cf8;
	localparam int SMI_LEVEL = 2;
	// ************************************
	// host cycle states
	// ************************************
	typedef enum logic [2:0] {
		HC_IDLE = 3'b001,
		HC_WR = 3'b010,
		HC_RD = 3'b100
	} isarr_host_e;
endpackage

// ---- src/isarr_cfg_if.sv ----
// per-unit routing configuration carried from bank to router
`timescale 1ns/1ps
`default_nettype none
interface isarr_cfg_if;
	logic usable;
	logic [3:0] level;
	logic [2:0] dma_sel;
	logic irq_en;
	logic dma_en;
	logic irq_req;
	logic drq;
	logic low_pol;
	modport bank(output usable, level, dma_sel, irq_en, dma_en, irq_req, drq, low_pol);
	modport route(input usable, level, dma_sel, irq_en, dma_en, irq_req, drq, low_pol);
endinterface
`default_nettype wire

// ---- src/isarr_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module isarr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- src/isarr_route.sv ----
// one unit's interrupt level and dma channel steering
`timescale 1ns/1ps
`default_nettype none
module isarr_route (
	isarr_cfg_if.route cfg,
	output logic [15:0] irq_drive,
	output logic [15:0] irq_val,
	output logic [3:0] dma_drive,
	output logic [3:0] dma_val
);
	logic irq_on;
	logic dma_on;
	logic pin_level;
	always_comb begin
		irq_on = cfg.usable && (cfg.level != 4'h0) && cfg.irq_en;
		dma_on = cfg.usable && cfg.dma_en && (cfg.dma_sel >= 3'h1)
			&& (cfg.dma_sel <= 3'h3);
		pin_level = cfg.low_pol ? !cfg.irq_req : cfg.irq_req;
		irq_drive = '0;
		irq_val = '0;
		dma_drive = '0;
		dma_val = '0;
		if (irq_on) begin
			irq_drive[cfg.level] = 1'b1;
			irq_val[cfg.level] = pin_level;
		end
		if (dma_on) begin
			dma_drive[cfg.dma_sel[1:0]] = 1'b1;
			dma_val[cfg.dma_sel[1:0]] = cfg.drq;
		end
	end
endmodule
`default_nettype wire

// ---- src/isarr_top.sv ----
// isa resource routing: config bank, address decode, irq and dma pins
`timescale 1ns/1ps
`default_nettype none
module isarr_top (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [15:0] SA,
	input wire logic [7:0] SD_IN,
	output logic [7:0] SD_OUT,
	output logic SD_OE,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic AEN,
	input wire logic SERIRQ_MODE,
	input wire logic [7:0] FLOPPY_DIGITAL_OUTPUT_REG,
	input wire logic [7:0] PP_CTRL,
	input wire logic [7:0] PP_ECR,
	input wire logic [7:0] UART1_INT_ENABLE_REG,
	input wire logic [7:0] UART1_MODEM_CTRL_REG,
	input wire logic [7:0] UART2_INT_ENABLE_REG,
	input wire logic [7:0] UART2_MODEM_CTRL_REG,
	input wire logic UART2_DMA_GATE,
	input wire logic [4:0] UNIT_INT_REQ,
	input wire logic [4:0] UNIT_DMA_REQ,
	output logic [4:0] UNIT_SEL,
	output logic PP_EPP_OK,
	output logic [15:0] IRQ_OUT,
	output logic [15:0] IRQ_OE,
	output logic SYSMGMT_INT_LOW,
	output logic [3:0] DMA_REQUEST_PIN,
	output logic [3:0] DMA_REQUEST_OE
);
	// ************************************
	// pin synchronisers
	// ************************************
	logic [15:0] sa_s;
	logic [7:0] sd_s;
	logic ior_n_s;
	logic iow_n_s;
	logic aen_s;
	logic serirq_s;
	isarr_sync #(.W(28), .INIT({16'h0000, 8'h00, 4'he})) u_sync_pins (
		.clk(REF_CLK),
		.rst(RST),
		.d({SA, SD_IN, IOR_N, IOW_N, AEN, SERIRQ_MODE}),
		.q({sa_s, sd_s, ior_n_s, iow_n_s, aen_s, serirq_s})
	);

	// ************************************
	// configuration storage
	// ************************************
	logic [7:0] idx_reg;
	logic [7:0] ldn_reg;
	logic [7:0] act_reg [8];
	logic [7:0] base_hi_reg [8];
	logic [7:0] base_lo_reg [8];
	logic [7:0] irq_reg [8];
	logic [7:0] dma_reg [8];
	isarr_pkg::isarr_host_e state_reg;
	isarr_pkg::isarr_host_e state_next;
	logic hit_idx;
	logic hit_dat;
	logic wr_take;
	logic bank_ok;
	logic bank_has_base;
	logic bank_has_dma;
	logic [2:0] bank;

	assign hit_idx = !aen_s && (sa_s == isarr_pkg::CFG_INDEX_ADDR);
	assign hit_dat = !aen_s && (sa_s == isarr_pkg::CFG_DATA_ADDR);
	assign bank = ldn_reg[2:0];
	assign bank_ok = (ldn_reg[7:3] == 5'h00) && ((bank == isarr_pkg::LDN_FDC)
		|| (bank == isarr_pkg::LDN_PP) || (bank == isarr_pkg::LDN_SP1)
		|| (bank == isarr_pkg::LDN_SP2) || (bank == isarr_pkg::LDN_KBD));
	assign bank_has_base = bank_ok && (bank != isarr_pkg::LDN_KBD);
	assign bank_has_dma = bank_ok && ((bank == isarr_pkg::LDN_FDC)
		|| (bank == isarr_pkg::LDN_PP) || (bank == isarr_pkg::LDN_SP2));

	// ************************************
	// host cycle sequencing
	// ************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			isarr_pkg::HC_IDLE: begin
				if (!iow_n_s) begin
					state_next = isarr_pkg::HC_WR;
				end else if (!ior_n_s) begin
					state_next = isarr_pkg::HC_RD;
				end
			end
			isarr_pkg::HC_WR: begin
				if (iow_n_s) begin
					state_next = isarr_pkg::HC_IDLE;
				end
			end
			isarr_pkg::HC_RD: begin
				if (ior_n_s) begin
					state_next = isarr_pkg::HC_IDLE;
				end
			end
			default: begin
				state_next = isarr_pkg::HC_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_reg <= isarr_pkg::HC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// one write per host write strobe
	assign wr_take = (state_reg == isarr_pkg::HC_IDLE) && !iow_n_s;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			idx_reg <= 8'h00;
			ldn_reg <= isarr_pkg::RST_LDN;
		end else if (wr_take && hit_idx) begin
			idx_reg <= sd_s;
		end else if (wr_take && hit_dat && (idx_reg == isarr_pkg::IDX_LDN)) begin
			ldn_reg <= sd_s;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int i = 0; i < 8; i++) begin
				act_reg[i] <= isarr_pkg::RST_ACT;
				base_hi_reg[i] <= isarr_pkg::RST_BASE;
				base_lo_reg[i] <= isarr_pkg::RST_BASE;
				irq_reg[i] <= isarr_pkg::RST_IRQ;
				dma_reg[i] <= isarr_pkg::RST_DMA;
			end
		end else if (wr_take && hit_dat && bank_ok) begin
			case (idx_reg)
				isarr_pkg::IDX_ACT: begin
					act_reg[bank] <= {7'h00, sd_s[0]};
				end
				isarr_pkg::IDX_BASE_HI: begin
					if (bank_has_base) begin
						base_hi_reg[bank] <= sd_s;
					end
				end
				isarr_pkg::IDX_BASE_LO: begin
					if (bank_has_base) begin
						base_lo_reg[bank] <= sd_s;
					end
				end
				isarr_pkg::IDX_IRQ: begin
					irq_reg[bank] <= sd_s;
				end
				isarr_pkg::IDX_DMA: begin
					if (bank_has_dma) begin
						dma_reg[bank] <= sd_s;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************
	// configuration read back
	// ************************************
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (hit_idx) begin
			rd_mux = idx_reg;
		end else if (idx_reg == isarr_pkg::IDX_LDN) begin
			rd_mux = ldn_reg;
		end else if (bank_ok) begin
			case (idx_reg)
				isarr_pkg::IDX_ACT: rd_mux = act_reg[bank];
				isarr_pkg::IDX_BASE_HI: rd_mux = base_hi_reg[bank];
				isarr_pkg::IDX_BASE_LO: rd_mux = base_lo_reg[bank];
				isarr_pkg::IDX_IRQ: rd_mux = irq_reg[bank];
				isarr_pkg::IDX_DMA: rd_mux = dma_reg[bank];
				default: rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SD_OUT <= 8'h00;
			SD_OE <= 1'b0;
		end else begin
			SD_OUT <= rd_mux;
			SD_OE <= !ior_n_s && (hit_idx || hit_dat);
		end
	end

	// ************************************
	// base range checks and decode
	// ************************************
	localparam int UNIT_N_L = isarr_pkg::UNIT_N;
	localparam logic [2:0] UNIT_LDN [UNIT_N_L] = '{
		isarr_pkg::LDN_FDC, isarr_pkg::LDN_PP, isarr_pkg::LDN_SP1,
		isarr_pkg::LDN_SP2, isarr_pkg::LDN_KBD};
	logic [15:0] ubase [UNIT_N_L];
	logic [UNIT_N_L-1:0] base_ok;
	logic [UNIT_N_L-1:0] active;
	logic [UNIT_N_L-1:0] hit;
	logic [11:0] a12;
	logic [11:0] pp_ecp_base;
	logic cyc;
	assign a12 = sa_s[11:0];
	assign cyc = !aen_s && (!ior_n_s || !iow_n_s);
	always_comb begin
		for (int u = 0; u < UNIT_N_L; u++) begin
			ubase[u] = {base_hi_reg[UNIT_LDN[u]], base_lo_reg[UNIT_LDN[u]]};
			active[u] = act_reg[UNIT_LDN[u]][0];
			base_ok[u] = (ubase[u][15:12] == 4'h0) && (ubase[u][11:0] >= isarr_pkg::BASE_MIN)
				&& (ubase[u][11:0] <= isarr_pkg::BASE_MAX8) && (ubase[u][2:0] == 3'h0);
		end
		base_ok[isarr_pkg::U_PP] = (ubase[isarr_pkg::U_PP][15:12] == 4'h0)
			&& (ubase[isarr_pkg::U_PP][11:0] >= isarr_pkg::BASE_MIN)
			&& (ubase[isarr_pkg::U_PP][11:0] <= isarr_pkg::BASE_MAX4)
			&& (ubase[isarr_pkg::U_PP][1:0] == 2'h0);
		base_ok[isarr_pkg::U_KBD] = 1'b1;
	end
	assign pp_ecp_base = ubase[isarr_pkg::U_PP][11:0] + isarr_pkg::ECP_OFS;
	always_comb begin
		for (int u = 0; u < UNIT_N_L; u++) begin
			hit[u] = (a12[11:3] == ubase[u][11:3]);
		end
		hit[isarr_pkg::U_PP] = ((ubase[isarr_pkg::U_PP][2] == 1'b0)
			? (a12[11:3] == ubase[isarr_pkg::U_PP][11:3])
			: (a12[11:2] == ubase[isarr_pkg::U_PP][11:2]))
			|| (a12[11:2] == pp_ecp_base[11:2]);
		hit[isarr_pkg::U_KBD] = (a12 == isarr_pkg::KBD_DATA_ADDR)
			|| (a12 == isarr_pkg::KBD_CMD_ADDR);
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			UNIT_SEL <= '0;
			PP_EPP_OK <= 1'b0;
		end else begin
			UNIT_SEL <= {UNIT_N_L{cyc}} & hit & active & base_ok;
			PP_EPP_OK <= base_ok[isarr_pkg::U_PP]
				&& (ubase[isarr_pkg::U_PP][2:0] == 3'h0);
		end
	end

	// ************************************
	// unit enables
	// ************************************
	logic [2:0] pp_mode;
	logic pp_ecp;
	logic [UNIT_N_L-1:0] irq_en;
	logic [UNIT_N_L-1:0] dma_en;
	assign pp_mode = PP_ECR[isarr_pkg::ECR_MODE_LSB +: 3];
	assign pp_ecp = (pp_mode == isarr_pkg::ECR_MODE_ECP);
	always_comb begin
		irq_en[isarr_pkg::U_FDC] = FLOPPY_DIGITAL_OUTPUT_REG[isarr_pkg::DOR_DMA_BIT];
		dma_en[isarr_pkg::U_FDC] = FLOPPY_DIGITAL_OUTPUT_REG[isarr_pkg::DOR_DMA_BIT];
		irq_en[isarr_pkg::U_PP] = PP_CTRL[isarr_pkg::PP_PPORT_INT_GATE_BIT]
			&& !(pp_ecp && PP_ECR[isarr_pkg::ECR_SVC_BIT]);
		dma_en[isarr_pkg::U_PP] = !pp_ecp || PP_ECR[isarr_pkg::ECR_DMA_BIT];
		irq_en[isarr_pkg::U_SP1] = (UART1_INT_ENABLE_REG[3:0] != 4'h0)
			&& UART1_MODEM_CTRL_REG[isarr_pkg::MCR_UART_IRQ_OUTPUT_GATE_BIT];
		dma_en[isarr_pkg::U_SP1] = 1'b0;
		irq_en[isarr_pkg::U_SP2] = (UART2_INT_ENABLE_REG[3:0] != 4'h0)
			&& UART2_MODEM_CTRL_REG[isarr_pkg::MCR_UART_IRQ_OUTPUT_GATE_BIT];
		dma_en[isarr_pkg::U_SP2] = UART2_DMA_GATE;
		irq_en[isarr_pkg::U_KBD] = 1'b1;
		dma_en[isarr_pkg::U_KBD] = 1'b0;
	end

	// ************************************
	// per-unit routers
	// ************************************
	logic [15:0] u_irq_drive [UNIT_N_L];
	logic [15:0] u_irq_val [UNIT_N_L];
	logic [3:0] u_dma_drive [UNIT_N_L];
	logic [3:0] u_dma_val [UNIT_N_L];

	for (genvar g = 0; g < UNIT_N_L; g++) begin : g_unit
		isarr_cfg_if cfg ();
		assign cfg.usable = active[g] && base_ok[g];
		assign cfg.level = irq_reg[UNIT_LDN[g]][3:0];
		assign cfg.dma_sel = dma_reg[UNIT_LDN[g]][2:0];
		assign cfg.irq_en = irq_en[g];
		assign cfg.dma_en = dma_en[g];
		assign cfg.irq_req = UNIT_INT_REQ[g];
		assign cfg.drq = UNIT_DMA_REQ[g];
		assign cfg.low_pol = (g == isarr_pkg::U_PP)
			&& (pp_ecp || (pp_mode == isarr_pkg::ECR_MODE_EPP));
		isarr_route u_route (
			.cfg(cfg.route),
			.irq_drive(u_irq_drive[g]),
			.irq_val(u_irq_val[g]),
			.dma_drive(u_dma_drive[g]),
			.dma_val(u_dma_val[g])
		);
	end

	// ************************************
	// pin merge and drive
	// ************************************
	logic [15:0] irq_drive;
	logic [15:0] irq_val;
	logic [3:0] dma_drive;
	logic [3:0] dma_val;
	logic [15:0] lvl_ok;
	always_comb begin
		irq_drive = '0;
		irq_val = '0;
		dma_drive = '0;
		dma_val = '0;
		for (int u = 0; u < UNIT_N_L; u++) begin
			irq_drive = irq_drive | u_irq_drive[u];
			irq_val = irq_val | u_irq_val[u];
			dma_drive = dma_drive | u_dma_drive[u];
			dma_val = dma_val | u_dma_val[u];
		end
		lvl_ok = serirq_s ? 16'hfffe : isarr_pkg::PAR_IRQ_MASK;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			IRQ_OUT <= '0;
			IRQ_OE <= '0;
			SYSMGMT_INT_LOW <= 1'b1;
			DMA_REQUEST_PIN <= '0;
			DMA_REQUEST_OE <= '0;
		end else begin
			IRQ_OUT <= irq_val & irq_drive & lvl_ok;
			IRQ_OE <= irq_drive & lvl_ok;
			SYSMGMT_INT_LOW <= !(irq_drive[isarr_pkg::SMI_LEVEL]
				&& irq_val[isarr_pkg::SMI_LEVEL]);
			DMA_REQUEST_PIN <= dma_val & dma_drive & 4'he;
			DMA_REQUEST_OE <= dma_drive & 4'he;
		end
	end
endmodule
`default_nettype wire

// ---- verif/isarr_top_props.sv ----
// assertions on the ports of the routing block
`timescale 1ns/1ps
`default_nettype none
module isarr_top_props (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [15:0] SA,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic AEN,
	input wire logic SERIRQ_MODE,
	input wire logic [7:0] PP_ECR,
	input wire logic [4:0] UNIT_INT_REQ,
	input wire logic [4:0] UNIT_DMA_REQ,
	input wire logic SD_OE,
	input wire logic [4:0] UNIT_SEL,
	input wire logic [15:0] IRQ_OUT,
	input wire logic [15:0] IRQ_OE,
	input wire logic SYSMGMT_INT_LOW,
	input wire logic [3:0] DMA_REQUEST_PIN,
	input wire logic [3:0] DMA_REQUEST_OE
);
	logic ext_mode;
	assign ext_mode = PP_ECR[7:5] inside {isarr_pkg::ECR_MODE_ECP, isarr_pkg::ECR_MODE_EPP};
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence s_no_int;
		(UNIT_INT_REQ == 5'h00 && !ext_mode) [*2];
	endsequence
	sequence s_no_drq;
		(UNIT_DMA_REQ == 5'h00) [*2];
	endsequence
	property p_sd_oe;
		SD_OE |-> !$past(IOR_N, 3) && $past(SA, 3) inside {16'h03f0, 16'h03f1};
	endproperty
	a_sd_oe: assert property (p_sd_oe) else $error("read data driven off cycle");
	property p_sel;
		(UNIT_SEL != 5'h00) |-> !$past(IOR_N && IOW_N, 3) && !$past(AEN, 3);
	endproperty
	a_sel: assert property (p_sel) else $error("unit select without strobe");
	property p_kbd;
		UNIT_SEL[4] |-> $past(SA[11:0], 3) inside {12'h060, 12'h064};
	endproperty
	a_kbd: assert property (p_kbd) else $error("keyboard select off fixed address");
	property p_lvl0;
		!IRQ_OE[0] && !IRQ_OUT[0];
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("line zero driven");
	property p_dma0;
		!DMA_REQUEST_OE[0];
	endproperty
	a_dma0: assert property (p_dma0) else $error("dma channel zero driven");
	property p_pin_mode;
		(!SERIRQ_MODE) [*4] |-> (IRQ_OE & 16'he307) == 16'h0000;
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("level unusable in pin mode");
	property p_irq_quiet;
		s_no_int |=> (IRQ_OUT & IRQ_OE) == 16'h0000;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq high with no request");
	property p_smi_quiet;
		s_no_int |=> SYSMGMT_INT_LOW;
	endproperty
	a_smi_quiet: assert property (p_smi_quiet) else $error("sysmgmt low with no request");
	property p_dma_quiet;
		s_no_drq |=> (DMA_REQUEST_PIN & DMA_REQUEST_OE) == 4'h0;
	endproperty
	a_dma_quiet: assert property (p_dma_quiet) else $error("dma high with no request");
endmodule
bind isarr_top isarr_top_props i_props (.REF_CLK(REF_CLK), .RST(RST), .SA(SA), .IOR_N(IOR_N),
	.IOW_N(IOW_N), .AEN(AEN), .SERIRQ_MODE(SERIRQ_MODE), .PP_ECR(PP_ECR),
	.UNIT_INT_REQ(UNIT_INT_REQ), .UNIT_DMA_REQ(UNIT_DMA_REQ), .SD_OE(SD_OE),
	.UNIT_SEL(UNIT_SEL), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .SYSMGMT_INT_LOW(SYSMGMT_INT_LOW),
	.DMA_REQUEST_PIN(DMA_REQUEST_PIN), .DMA_REQUEST_OE(DMA_REQUEST_OE));
`default_nettype wire

// ---- verif/isarr_bus_model.sv ----
// host side irq and dma lines as the controllers see them
`timescale 1ns/1ps
`default_nettype none
module isarr_bus_model (
	input wire logic clk,
	input wire logic [15:0] irq_out,
	input wire logic [15:0] irq_oe,
	input wire logic [3:0] drq_out,
	input wire logic [3:0] drq_oe,
	output logic [15:0] irq_line,
	output logic [3:0] drq_line
);
	logic [15:0] irq_last = 16'h0000;
	logic [3:0] drq_last = 4'h0;
	always @(posedge clk) begin
		irq_last <= irq_line;
		drq_last <= drq_line;
	end
	// released lines toggle instead of holding
	assign irq_line = (irq_oe & irq_out) | (~irq_oe & ~irq_last);
	assign drq_line = (drq_oe & drq_out) | (~drq_oe & ~drq_last);
endmodule
`default_nettype wire

// ---- verif/isa_resource_routing_test.sv ----
// self-checking bench for the routing block
`timescale 1ns/1ps
`default_nettype none
module isa_resource_routing_test;
	logic clk = 0, rst = 1, ior_n = 1, iow_n = 1, ser = 0, u2dg = 0, aen = 0;
	logic [15:0] sa = 0, ex, irl;
	logic [7:0] sdi = 0, floppy_digital_output_reg = 0, ppc = 0, ecr = 0, ier1 = 0, mcr1 = 0, ier2 = 0, mcr2 = 0, q;
	logic [4:0] ireq = 0, dreq = 0, sel;
	logic [7:0] sdo;
	logic sdoe, epp, smi;
	logic [15:0] iro, iroe;
	logic [3:0] dp, doe, drl;
	int miscompares = 0, total_checks = 0;
	isarr_top i_dut (.REF_CLK(clk), .RST(rst), .SA(sa), .SD_IN(sdi), .SD_OUT(sdo), .SD_OE(sdoe),
		.IOR_N(ior_n), .IOW_N(iow_n), .AEN(aen), .SERIRQ_MODE(ser),
		.FLOPPY_DIGITAL_OUTPUT_REG(floppy_digital_output_reg), .PP_CTRL(ppc), .PP_ECR(ecr),
		.UART1_INT_ENABLE_REG(ier1), .UART1_MODEM_CTRL_REG(mcr1), .UART2_INT_ENABLE_REG(ier2),
		.UART2_MODEM_CTRL_REG(mcr2), .UART2_DMA_GATE(u2dg), .UNIT_INT_REQ(ireq),
		.UNIT_DMA_REQ(dreq), .UNIT_SEL(sel), .PP_EPP_OK(epp), .IRQ_OUT(iro), .IRQ_OE(iroe),
		.SYSMGMT_INT_LOW(smi), .DMA_REQUEST_PIN(dp), .DMA_REQUEST_OE(doe));
	isarr_bus_model i_host (.clk(clk), .irq_out(iro), .irq_oe(iroe), .drq_out(dp),
		.drq_oe(doe), .irq_line(irl), .drq_line(drl));
	// ************************************
	// clock, tasks
	// ************************************
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic st();
		repeat (4) @(negedge clk);
	endtask
	task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic r);
		int n;
		@(negedge clk);
		sa = a;
		sdi = d;
		ior_n = !r;
		iow_n = r;
		n = 0;
		st();
		while (r && sdoe !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		q = sdo;
		if (r) begin
			chk("rd_oe", sdoe, 1'b1);
		end
		ior_n = 1'b1;
		iow_n = 1'b1;
		st();
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		bus(16'h03f0, i, 1'b0);
		bus(16'h03f1, v, 1'b0);
	endtask
	task automatic rdc(input logic [7:0] i, input logic [7:0] e, input string n);
		bus(16'h03f0, i, 1'b0);
		bus(16'h03f1, 8'h00, 1'b1);
		chk(n, q, e);
	endtask
	task automatic pr(input logic [15:0] a, input logic [4:0] e, input string n);
		sa = a;
		ior_n = 1'b0;
		st();
		chk(n, sel, e);
		ior_n = 1'b1;
		st();
	endtask
	task automatic cfg(input logic [2:0] l, input logic [15:0] b, input logic [7:0] i, d);
		wr(8'h07, {5'h00, l});
		wr(8'h60, b[15:8]);
		wr(8'h61, b[7:0]);
		wr(8'h70, i);
		wr(8'h74, d);
		wr(8'h30, 8'h01);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report();
	end
	// ************************************
	// tests
	// ************************************
	initial begin
		repeat (4) @(negedge clk);
		rst = 0;
		chk("irq_oe_rst", iroe, 16'h0000);
		chk("smi_rst", smi, 1'b1);
		rdc(8'h70, 8'h00, "irq_rst");
		rdc(8'h74, 8'h04, "dma_rst");
		rdc(8'h31, 8'h00, "unmapped");
		$display("test reset done");
		cfg(isarr_pkg::LDN_FDC, 16'h0200, 8'h06, 8'h02);
		ireq = 5'h01;
		dreq = 5'h01;
		st();
		chk("fdc_irq_off", iroe, 16'h0000);
		chk("fdc_dma_off", doe, 4'h0);
		floppy_digital_output_reg = 8'h08;
		st();
		chk("fdc_irq_oe", iroe, 16'h0040);
		chk("fdc_irq_line", irl[6], 1'b1);
		chk("fdc_dma_oe", doe, 4'h4);
		chk("fdc_drq_line", drl[2], 1'b1);
		rdc(8'h70, 8'h06, "bank_fdc");
		pr(16'h0207, 5'h01, "fdc_top");
		pr(16'h0208, 5'h00, "fdc_past");
		pr(16'hf203, 5'h01, "fdc_alias");
		// only this unit uses line 2, sysmgmt otherwise unused
		for (int m = 0; m < 2; m++) begin
			for (int lv = 0; lv < 16; lv++) begin
				ser = m[0];
				wr(8'h70, 8'(lv));
				st();
				ex = (lv == 0) ? 16'h0000 : 16'h0001 << lv;
				if (m == 0 && !(lv inside {[3:7], [10:12]})) ex = 16'h0000;
				if (lv == 2) begin
					chk("smi_lvl2", smi, 1'b0);
				end else begin
					chk("irq_lvl", iroe, ex);
					chk("smi_idle", smi, 1'b1);
				end
			end
		end
		ser = 1'b0;
		for (int d = 0; d < 8; d++) begin
			wr(8'h74, 8'(d));
			st();
			chk("dma_sel", doe, (d >= 1 && d <= 3) ? 4'h1 << d : 4'h0);
		end
		wr(8'h60, 8'h00);
		wr(8'h61, 8'hf8);
		pr(16'h00f8, 5'h00, "fdc_low");
		wr(8'h60, 8'h0f);
		pr(16'h0fff, 5'h01, "fdc_max");
		$display("test floppy done");
		cfg(isarr_pkg::LDN_KBD, 16'h0300, 8'h01, 8'h01);
		pr(16'h0060, 5'h10, "kbd_data");
		pr(16'h0064, 5'h10, "kbd_cmd");
		pr(16'h0300, 5'h00, "kbd_nobase");
		aen = 1'b1;
		pr(16'h0060, 5'h00, "kbd_aen");
		aen = 1'b0;
		$display("test keyboard done");
		cfg(isarr_pkg::LDN_PP, 16'h027c, 8'h07, 8'h03);
		ireq = 5'h03;
		dreq = 5'h03;
		st();
		chk("pp_gate_off", iroe[7], 1'b0);
		ppc = 8'h10;
		st();
		chk("pp_gate_on", iroe[7], 1'b1);
		chk("pp_epp4", epp, 1'b0);
		pr(16'h027f, 5'h02, "pp_dec4");
		wr(8'h61, 8'h78);
		chk("pp_epp8", epp, 1'b1);
		ecr = 8'h60;
		st();
		chk("ecp_irq_low", iro[7], 1'b0);
		chk("ecp_dma_off", doe[3], 1'b0);
		ecr = 8'h6c;
		st();
		chk("ecp_irq_mask", iroe[7], 1'b0);
		chk("ecp_dma_on", doe[3], 1'b1);
		ecr = 8'h80;
		st();
		chk("epp_irq_oe", iroe[7], 1'b1);
		chk("epp_irq_low", iro[7], 1'b0);
		chk("epp_dma_on", doe[3], 1'b1);
		ecr = 8'h00;
		$display("test parallel done");
		cfg(isarr_pkg::LDN_SP1, 16'h02f8, 8'h04, 8'h00);
		ireq = 5'h07;
		mcr1 = 8'h04;
		st();
		chk("sp1_no_ier", iroe[4], 1'b0);
		ier1 = 8'h08;
		mcr1 = 8'h00;
		st();
		chk("sp1_no_uart_irq_output_gate", iroe[4], 1'b0);
		mcr1 = 8'h04;
		st();
		chk("sp1_on", iroe[4], 1'b1);
		cfg(isarr_pkg::LDN_SP2, 16'h03e8, 8'h05, 8'h01);
		ier2 = 8'h01;
		mcr2 = 8'h04;
		ireq = 5'h0f;
		dreq = 5'h0b;
		st();
		chk("sp2_irq", iroe[5], 1'b1);
		chk("sp2_dma_off", doe[1], 1'b0);
		u2dg = 1'b1;
		st();
		chk("sp2_dma_on", doe[1], 1'b1);
		$display("test serial done");
		final_report();
	end
endmodule
`default_nettype wire
